/* spme_pkg.sv */
package spme_pkg;
    // number of port bits, the two serial pins included
    localparam int PORT_W = 8;
    // port0 bit positions shared with the serial link
    localparam int TX_BIT = 0;
    localparam int RX_BIT = 1;
    // level forced onto gated port inputs
    localparam logic [PORT_W-1:0] GATED_IN = 8'h00;
    // strap level that requests programming mode
    localparam logic STRAP_ON = 1'b1;
    // reset values
    localparam logic MODE_RESET = 1'b0;
    localparam logic EN_RESET = 1'b0;
    localparam logic SER_IDLE = 1'b1;
    // link defaults (shared with the far end)
    localparam int BAUD_DEFAULT = 9600;
    localparam int DATA_BITS = 8;
    localparam int STOP_BITS = 1;
    localparam logic [7:0] MATCH_BYTE = 8'h5a;

    // each decided mode is one bit away from the undecided state
    typedef enum logic [1:0] {
        SPME_RESET = 2'b00,
        SPME_RUN = 2'b01,
        SPME_PROG = 2'b10
    } spme_state_t;

    // one port bank seen from the core
    typedef struct packed {
        logic [PORT_W-1:0] out;
        logic [PORT_W-1:0] oe;
    } spme_port_drv_t;
endpackage : spme_pkg

/* spme_mode_entry.sv */
`timescale 1ns/1ps
`default_nettype none
module spme_mode_entry (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ce,
    // mode straps
    input wire logic i_prog_strap,
    // port pins (bit 0 transmit, bit 1 select/receive)
    input wire logic [spme_pkg::PORT_W-1:0] i_port_pin,
    output logic [spme_pkg::PORT_W-1:0] o_port_out,
    output logic [spme_pkg::PORT_W-1:0] o_port_oe,
    // core side: port drive and sampled inputs
    input wire spme_pkg::spme_port_drv_t i_core_port,
    output logic [spme_pkg::PORT_W-1:0] o_core_port_in,
    // core side: serial link in programming mode
    input wire logic i_uart_txd,
    output logic o_uart_rxd,
    // port_input_enable_ctrl write from loaded program
    input wire logic i_in_en_wr,
    input wire logic i_in_en_data,
    // status
    output logic o_prog_mode,
    output logic o_in_enabled
);
    // mode group: undecided, run or programming
    spme_pkg::spme_state_t state_reg, state_next;

    // input enable group, the one bit the loaded program writes
    logic in_en_reg, in_en_next;

    // pin drive group, carried as one struct
    spme_pkg::spme_port_drv_t pin_reg, pin_next;

    // core view of the port pins
    logic [spme_pkg::PORT_W-1:0] cin_reg, cin_next;

    // serial receive towards the core
    logic rxd_reg, rxd_next;

    // decoded mode flags, shared by the enable, pin, core input and receive groups below
    logic prog_mode;
    logic run_mode;

    // mask of the two serial pins, used in several places
    function automatic logic [spme_pkg::PORT_W-1:0] ser_mask();
        logic [spme_pkg::PORT_W-1:0] m;
        m = '0;
        m[spme_pkg::TX_BIT] = 1'b1;
        m[spme_pkg::RX_BIT] = 1'b1;
        return m;
    endfunction : ser_mask

    // true when both straps ask for programming mode;
    // the select pin doubles as a strap only in the undecided state
    function automatic logic strap_match(
        input logic prog_strap,
        input logic select_pin
    );
        return (prog_strap == spme_pkg::STRAP_ON) && (select_pin == spme_pkg::STRAP_ON);
    endfunction : strap_match

    // port inputs as the core sees them in programming mode;
    // serial bits always read as the gated level there
    function automatic logic [spme_pkg::PORT_W-1:0] gate_inputs(
        input logic [spme_pkg::PORT_W-1:0] pins,
        input logic enabled
    );
        logic [spme_pkg::PORT_W-1:0] g;
        g = spme_pkg::GATED_IN;
        if (enabled) begin
            g = pins & ~ser_mask();
        end
        return g;
    endfunction : gate_inputs

    // mode flags from the state register
    assign prog_mode = (state_reg == spme_pkg::SPME_PROG);
    assign run_mode = (state_reg == spme_pkg::SPME_RUN);

    // mode decision taken on the first enabled edge after reset release;
    // the straps are only looked at in the undecided state, so later
    // traffic on the shared pin cannot change the mode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            spme_pkg::SPME_RESET: begin
                if (strap_match(i_prog_strap, i_port_pin[spme_pkg::RX_BIT])) begin
                    state_next = spme_pkg::SPME_PROG;
                end else begin
                    state_next = spme_pkg::SPME_RUN;
                end
            end
            spme_pkg::SPME_PROG: begin
                state_next = spme_pkg::SPME_PROG;
            end
            spme_pkg::SPME_RUN: begin
                state_next = spme_pkg::SPME_RUN;
            end
            default: begin
                // unused code: fall back to a fresh decision
                state_next = spme_pkg::SPME_RESET;
            end
        endcase
    end

    // mode register; only reset leaves a decided mode
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_reg <= spme_pkg::SPME_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // input enable bit; writes outside programming mode are dropped
    // a refused write leaves no trace, so software reads the bit back
    always_comb begin
        in_en_next = in_en_reg;
        if (prog_mode && i_in_en_wr) begin
            in_en_next = i_in_en_data;
        end
    end

    // enable register, frozen with the rest while the enable is low
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            in_en_reg <= spme_pkg::EN_RESET;
        end else if (i_ce) begin
            in_en_reg <= in_en_next;
        end
    end

    // pin drive; registered so data outputs come from flip-flops
    // transmit is driven before the enable bit, so the link works first
    always_comb begin
        pin_next = i_core_port;
        if (prog_mode) begin
            // non-serial pins float until the program enables them
            pin_next.oe = in_en_reg ? (i_core_port.oe & ~ser_mask()) : '0;
            pin_next.out = i_core_port.out & ~ser_mask();
            pin_next.out[spme_pkg::TX_BIT] = i_uart_txd;
            pin_next.oe[spme_pkg::TX_BIT] = 1'b1;
            pin_next.oe[spme_pkg::RX_BIT] = 1'b0;
        end else if (!run_mode) begin
            // undecided: all pins released
            pin_next = '0;
        end
    end

    // pin drive register; released while in reset
    // costs one cycle of latency on every port write
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pin_reg <= '0;
        end else if (i_ce) begin
            pin_reg <= pin_next;
        end
    end

    // core view of the pins; gating stops floating pins causing overlap current
    // undecided state shows the gated level rather than a half-sampled port
    always_comb begin
        cin_next = i_port_pin;
        if (prog_mode) begin
            cin_next = gate_inputs(i_port_pin, in_en_reg);
        end else if (!run_mode) begin
            cin_next = spme_pkg::GATED_IN;
        end
    end

    // core input register
    // one cycle behind the pins, as the core expects of a port read
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            cin_reg <= spme_pkg::GATED_IN;
        end else if (i_ce) begin
            cin_reg <= cin_next;
        end
    end

    // receive line towards the core's serial unit;
    // idles high outside programming mode so no false start bit appears
    always_comb begin
        rxd_next = spme_pkg::SER_IDLE;
        if (prog_mode) begin
            rxd_next = i_port_pin[spme_pkg::RX_BIT];
        end
    end

    // receive register; bit timing is left to the core's serial unit
    // one cycle of delay is far below a bit time at the link rate
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rxd_reg <= spme_pkg::SER_IDLE;
        end else if (i_ce) begin
            rxd_reg <= rxd_next;
        end
    end

    // pin and enable outputs straight from registers, mode flag decoded from the state register
    assign o_port_out = pin_reg.out;
    assign o_port_oe = pin_reg.oe;
    assign o_core_port_in = cin_reg;
    assign o_uart_rxd = rxd_reg;
    assign o_prog_mode = prog_mode;
    assign o_in_enabled = in_en_reg;
endmodule : spme_mode_entry
`default_nettype wire

/* spme_mode_entry_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module spme_mode_entry_properties (
    // watched ports
    input wire logic i_clk, i_sys_rst, i_ce, i_prog_strap, i_uart_txd, i_in_en_wr,
    input wire logic i_in_en_data, o_uart_rxd, o_prog_mode, o_in_enabled,
    input wire logic [7:0] i_port_pin, o_port_out, o_port_oe, o_core_port_in,
    input wire spme_pkg::spme_port_drv_t i_core_port
);
    default clocking @(posedge i_clk); endclocking
    // a low enable freezes the block, so the checks pause too
    default disable iff (i_sys_rst || !i_ce);
    mode_entry_a: assert property ($fell(i_sys_rst) |=>
        o_prog_mode == ($past(i_prog_strap) && $past(i_port_pin[1]))) else $error("bad mode");
    prog_float_a: assert property (o_prog_mode && !o_in_enabled |=>
        o_port_oe == 8'h01) else $error("bad oe");
    prog_gate_a: assert property (o_prog_mode && !o_in_enabled |=>
        o_core_port_in == 8'h00) else $error("bad gate");
    prog_tx_a: assert property (o_prog_mode |=>
        o_port_out[0] == $past(i_uart_txd) && o_port_oe[0]) else $error("bad tx");
    prog_rx_a: assert property (o_prog_mode |=>
        o_uart_rxd == $past(i_port_pin[1])) else $error("bad rx");
    en_write_a: assert property (i_in_en_wr |=>
        o_in_enabled == ($past(i_in_en_data) && $past(o_prog_mode))) else $error("bad en");
    en_pass_a: assert property (o_prog_mode && o_in_enabled |=>
        o_core_port_in[7:2] == $past(i_port_pin[7:2])) else $error("bad pass");
    run_pass_a: assert property (!o_prog_mode && !$fell(i_sys_rst) |=>
        o_port_oe == $past(i_core_port.oe) && o_uart_rxd) else $error("bad run");
endmodule : spme_mode_entry_properties
bind spme_mode_entry spme_mode_entry_properties i_chk (.*);
`default_nettype wire

/* spme_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spme_ctrl_model #(
    parameter int BIT_CYC = 1042
) (
    // writer side lines
    input wire logic i_clk,
    output logic o_rst = 1'b1,
    output logic o_strap = 1'b0,
    output logic o_rx = 1'b1
);
    // reset held while straps settle, then released
    task session(input logic prog);
        @(posedge i_clk) #1 o_rst = 1'b1;
        o_strap = prog;
        o_rx = prog;
        repeat (2) @(posedge i_clk);
        #1 o_rst = 1'b0;
    endtask : session
    // 8n1 frame, lsb first; caller repeats it
    task send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int k = 0; k < 10; k++) begin
            @(posedge i_clk) #1 o_rx = f[k];
            repeat (BIT_CYC - 1) @(posedge i_clk);
        end
    endtask : send
endmodule : spme_ctrl_model
`default_nettype wire

/* spme_mode_entry_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module spme_mode_entry_tb_top;
    localparam int BIT_CYC = 1042; // 10 MHz over 9600 bps
    localparam logic [9:0] FRAME = {1'b1, 8'h5a, 1'b0};
    logic i_clk = 1'b0, i_ce = 1'b1, i_uart_txd = 1'b1, i_in_en_wr = 1'b0, i_in_en_data = 1'b0;
    logic i_sys_rst, i_prog_strap, rx, o_uart_rxd, o_prog_mode, o_in_enabled;
    logic [7:0] ext = 8'hb4, i_port_pin, o_port_out, o_port_oe, o_core_port_in;
    spme_pkg::spme_port_drv_t i_core_port = '0;
    int fail_count = 0, check_count = 0, cyc = 0;
    always #50 i_clk = ~i_clk;
    // device drive wins, otherwise the outside level
    assign i_port_pin = (o_port_oe & o_port_out) | (~o_port_oe & {ext[7:2], rx, ext[0]});
    spme_ctrl_model #(.BIT_CYC(BIT_CYC)) i_ctrl (.i_clk(i_clk), .o_rst(i_sys_rst),
        .o_strap(i_prog_strap), .o_rx(rx));
    spme_mode_entry i_dut (.*);
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : stop_test
    // hang guard, above two frames plus setup
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    // entry, matching frames, then input enable
    task t_prog;
        i_ctrl.session(1'b1);
        i_core_port = '{out: 8'h00, oe: 8'hff};
        repeat (3) @(posedge i_clk);
        #1 chk("mode", {7'h00, o_prog_mode}, 8'h01);
        chk("oe", o_port_oe, 8'h01);
        chk("cin", o_core_port_in, 8'h00);
        chk("tx", {7'h00, o_port_out[0]}, 8'h01);
        for (int r = 0; r < 2; r++) fork
            i_ctrl.send(8'h5a);
            for (int k = 0; k < 10; k++) begin
                repeat (k > 0 ? BIT_CYC : BIT_CYC / 2) @(posedge i_clk);
                #1 chk("rxd", {7'h00, o_uart_rxd}, {7'h00, FRAME[k]});
            end
        join
        #1 i_in_en_wr = 1'b1;
        i_in_en_data = 1'b1;
        i_core_port = '0;
        @(posedge i_clk) #1 i_in_en_wr = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk("cin", o_core_port_in, 8'hb4);
        chk("en", {7'h00, o_in_enabled}, 8'h01);
    endtask : t_prog
    // second reset with straps low: plain ports, enable refused
    task t_run;
        i_ctrl.session(1'b0);
        i_core_port = '{out: 8'h5a, oe: 8'hc3};
        i_in_en_wr = 1'b1;
        repeat (3) @(posedge i_clk);
        #1 chk("mode", {7'h00, o_prog_mode}, 8'h00);
        chk("out", o_port_out, 8'h5a);
        chk("cin", o_core_port_in, 8'h76);
        chk("en", {7'h00, o_in_enabled}, 8'h00);
        // enable low freezes the registers, high lets them move again
        i_ce = 1'b0;
        i_core_port = '{out: 8'ha5, oe: 8'hc3};
        repeat (2) @(posedge i_clk);
        #1 chk("hold", o_port_out, 8'h5a);
        i_ce = 1'b1;
        repeat (2) @(posedge i_clk);
        #1 chk("out", o_port_out, 8'ha5);
    endtask : t_run
    initial begin
        t_prog;
        t_run;
        stop_test();
    end
endmodule : spme_mode_entry_tb_top
`default_nettype wire
